/* tcb_bus_port.sv */
// Host backplane bus port: register window, interrupts, DMA master
// Behaviour
// [R1] Address then data share the same multiplexed lines each transfer.
// [R2] Lines 21..18 carry address only, never data.
// [R3] Lines 17 and 16 carry parity status during data transfers.
// [R4] One port serves register access, interrupts and DMA.
// [R5] Interrupt requested at levels 4 and 5 together.
// [R6] Eight-register I/O page window, base from address select switches.
// [R7] Power-good low or initialize gives full controller clear; the code clears on DC-ok low or initialize and ignores power-good.
// [R8] Self-test starts on power-up only, never on initialize.
// [R9] DMA transfers are sequenced by the microprocessor through requests.
// [R10] DMA memory read with parity error sets bus parity error bit.
// [R11] Transfers run on sync, din, dout, reply, write-byte and bs7.
// [R12] Microprocessor answers every register access and performs its function.
// [R13] Acknowledge and grant chains pass through when not requesting.
// [R14] Control lines active low except power-good and DC-ok.
`timescale 1ns/10ps
`include "tcb_cfg.svh"
module tcb_bus_port (
    input  wire logic                    clk_in,
    input  wire logic                    resetn_in,
    input  wire logic [21:0]             bdal_n_in,
    output logic      [21:0]             bdal_n_out,
    output logic      [21:0]             bdal_n_oe_out,
    input  wire logic                    bsync_n_in,
    output logic                         bsync_n_out,
    output logic                         bsync_n_oe_out,
    input  wire logic                    bdin_n_in,
    output logic                         bdin_n_out,
    output logic                         bdin_n_oe_out,
    input  wire logic                    bdout_n_in,
    output logic                         bdout_n_out,
    output logic                         bdout_n_oe_out,
    input  wire logic                    brply_n_in,
    output logic                         brply_n_out,
    output logic                         brply_n_oe_out,
    input  wire logic                    bwtbt_n_in,
    output logic                         bwtbt_n_out,
    output logic                         bwtbt_n_oe_out,
    input  wire logic                    bbs7_n_in,
    output logic                         birq4_n_out,
    output logic                         birq4_n_oe_out,
    output logic                         birq5_n_out,
    output logic                         birq5_n_oe_out,
    input  wire logic                    biaki_n_in,
    output logic                         biako_n_out,
    output logic                         bdmr_n_out,
    output logic                         bdmr_n_oe_out,
    input  wire logic                    bdmgi_n_in,
    output logic                         bdmgo_n_out,
    output logic                         bsack_n_out,
    output logic                         bsack_n_oe_out,
    input  wire logic                    binit_n_in,
    input  wire logic                    bdcok_in,
    input  wire logic                    bpok_in,
    input  wire logic [8:0]              address_select_switches_in,
    output tcb_pkg::tcb_pio_t            pio_req_out,
    output logic                         pio_valid_out,
    output logic      [15:0]             pio_wdata_out,
    input  wire logic                    pio_ack_in,
    input  wire logic [15:0]             pio_rdata_in,
    input  wire logic                    irq_req_in,
    input  wire logic [15:0]             irq_vector_in,
    output logic                         irq_taken_out,
    input  wire tcb_pkg::tcb_dma_t       dma_req_in,
    input  wire logic                    dma_valid_in,
    output logic                         dma_ready_out,
    output logic                         dma_done_out,
    output logic      [15:0]             dma_rdata_out,
    output logic                         bus_parity_error_bit_out,
    input  wire logic                    parity_clr_in,
    output logic                         controller_clear_out,
    output logic                         self_test_start_out
);
    import tcb_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [`TCB_NIN-1:0] raw, s1_q, s2_q, s3_q, f_q;
    assign raw = {bdcok_in, bpok_in, binit_n_in, bdmgi_n_in, biaki_n_in,
                  bbs7_n_in, bwtbt_n_in, brply_n_in, bdout_n_in, bdin_n_in,
                  bsync_n_in, bdal_n_in};
    for (genvar i = 0; i < `TCB_NIN; i++)
    begin : g_sync
        localparam logic [`TCB_NIN-1:0] RV_ALL = `TCB_IN_RST;
        localparam logic RV = RV_ALL[i];
        always_ff @(posedge clk_in)
        begin
            if (!resetn_in)
            begin
                s1_q[i] <= RV;
                s2_q[i] <= RV;
                s3_q[i] <= RV;
                f_q[i]  <= RV;
            end
            else
            begin
                s1_q[i] <= raw[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i])
                    f_q[i] <= s3_q[i];
            end
        end
    end

    // Asserted levels
    logic [21:0] bdal;
    logic sync_a, din_a, dout_a, rply_a, wtbt_a, bs7_a, iaki_a, dmgi_a;
    logic init_a, dcok, clr;
    assign bdal   = ~f_q[21:0];                          // R14
    assign sync_a = ~f_q[`TCB_I_SYNC];
    assign din_a  = ~f_q[`TCB_I_DIN];
    assign dout_a = ~f_q[`TCB_I_DOUT];
    assign rply_a = ~f_q[`TCB_I_RPLY];
    assign wtbt_a = ~f_q[`TCB_I_WTBT];
    assign bs7_a  = ~f_q[`TCB_I_BS7];
    assign iaki_a = ~f_q[`TCB_I_IAKI];
    assign dmgi_a = ~f_q[`TCB_I_DMGI];
    assign init_a = ~f_q[`TCB_I_INIT];
    assign dcok   = f_q[`TCB_I_DCOK];
    assign clr    = !dcok || init_a;                     // R7

    // ==========================================================
    // Clear and self-test
    logic dcok_prev_q;
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            dcok_prev_q          <= 1'b0;
            controller_clear_out <= 1'b1;
            self_test_start_out  <= 1'b0;
        end
        else
        begin
            dcok_prev_q          <= dcok;
            controller_clear_out <= clr;                 // R7
            self_test_start_out  <= dcok && !dcok_prev_q; // R8
        end
    end

    // ==========================================================
    // Transfer sequencer
    tcb_state_t  st_q;
    tcb_dma_t    dma_q;
    logic [21:0] drv_q, drv_oe_q;
    logic sync_oe_q, din_oe_q, dout_oe_q, rply_oe_q, wtbt_oe_q;
    logic dmr_oe_q, sack_oe_q, perr_set;
    logic hit, iak_go;

    assign hit = bs7_a && (bdal[`TCB_SEL_HI:`TCB_SEL_LO]
                 == address_select_switches_in);        // R6
    assign iak_go = din_a && iaki_a && irq_req_in && !sync_a;
    assign dma_ready_out = (st_q == TCB_IDLE) && !clr && !sync_a && !iak_go;
    assign perr_set = (st_q == TCB_DDAT) && rply_a && !dma_q.write
                      && bdal[`TCB_PAR_ERR];            // R10

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in || clr)
        begin
            st_q <= TCB_IDLE;
            dma_q <= '0;
            drv_q <= '0;
            drv_oe_q <= '0;
            {sync_oe_q, din_oe_q, dout_oe_q, rply_oe_q} <= 4'h0;
            {wtbt_oe_q, dmr_oe_q, sack_oe_q} <= 3'h0;
            pio_req_out <= '0;
            pio_valid_out <= 1'b0;
            pio_wdata_out <= '0;
            irq_taken_out <= 1'b0;
            dma_done_out <= 1'b0;
            dma_rdata_out <= '0;
        end
        else
        begin
            irq_taken_out <= 1'b0;
            dma_done_out  <= 1'b0;
            case (st_q)
                TCB_IDLE:
                begin
                    if (iak_go)                              // R4
                    begin
                        drv_q <= {6'h00, irq_vector_in};
                        drv_oe_q <= 22'h00ffff;
                        rply_oe_q <= 1'b1;
                        irq_taken_out <= 1'b1;
                        st_q <= TCB_VEC;
                    end
                    else if (sync_a)
                    begin
                        pio_req_out.idx <= bdal[`TCB_IDX_HI:`TCB_IDX_LO];
                        pio_req_out.addr0 <= bdal[0];
                        st_q <= hit ? TCB_ADDR : TCB_WAIT;   // R1 R6
                    end
                    else if (dma_valid_in)
                    begin
                        dma_q <= dma_req_in;
                        dmr_oe_q <= 1'b1;                    // R9
                        st_q <= TCB_DREQ;
                    end
                end
                TCB_ADDR:
                begin
                    if (din_a || dout_a)                     // R11
                    begin
                        pio_req_out.write <= dout_a;
                        pio_req_out.byte_op <= dout_a && wtbt_a;
                        pio_wdata_out <= bdal[15:0];
                        pio_valid_out <= 1'b1;               // R12
                        st_q <= TCB_PIO;
                    end
                    else if (!sync_a)
                        st_q <= TCB_IDLE;
                end
                TCB_PIO:
                begin
                    if (pio_ack_in)
                    begin
                        pio_valid_out <= 1'b0;
                        if (!pio_req_out.write)
                        begin
                            // Parity lines driven as no error
                            drv_q <= {6'h00, pio_rdata_in};  // R3
                            drv_oe_q <= 22'h03ffff;          // R2
                        end
                        rply_oe_q <= 1'b1;
                        st_q <= TCB_RPLY;
                    end
                end
                TCB_RPLY:
                begin
                    if (!din_a && !dout_a)
                    begin
                        drv_oe_q <= '0;
                        rply_oe_q <= 1'b0;
                        st_q <= TCB_WAIT;
                    end
                end
                TCB_WAIT:
                    if (!sync_a)
                        st_q <= TCB_IDLE;
                TCB_VEC:
                begin
                    if (!din_a)
                    begin
                        drv_oe_q <= '0;
                        rply_oe_q <= 1'b0;
                        st_q <= TCB_IDLE;
                    end
                end
                TCB_DREQ:
                begin
                    if (dmgi_a)
                    begin
                        dmr_oe_q <= 1'b0;
                        sack_oe_q <= 1'b1;
                        st_q <= TCB_DGNT;
                    end
                end
                TCB_DGNT:
                begin
                    if (!sync_a && !rply_a)
                    begin
                        drv_q <= dma_q.addr;                 // R1
                        drv_oe_q <= '1;
                        wtbt_oe_q <= dma_q.write;
                        st_q <= TCB_DADR;
                    end
                end
                TCB_DADR:
                begin
                    sync_oe_q <= 1'b1;
                    st_q <= TCB_DSTB;
                end
                TCB_DSTB:
                begin
                    drv_q <= {6'h00, dma_q.wdata};
                    drv_oe_q <= dma_q.write ? 22'h03ffff : '0; // R2 R3
                    wtbt_oe_q <= 1'b0;
                    dout_oe_q <= dma_q.write;
                    din_oe_q <= !dma_q.write;
                    st_q <= TCB_DDAT;
                end
                TCB_DDAT:
                begin
                    if (rply_a)
                    begin
                        dma_rdata_out <= bdal[15:0];
                        din_oe_q <= 1'b0;
                        dout_oe_q <= 1'b0;
                        st_q <= TCB_DEND;
                    end
                end
                TCB_DEND:
                begin
                    if (!rply_a)
                    begin
                        drv_oe_q <= '0;
                        sync_oe_q <= 1'b0;
                        sack_oe_q <= 1'b0;
                        dma_done_out <= 1'b1;
                        st_q <= TCB_IDLE;
                    end
                end
                default:
                    st_q <= TCB_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Parity flag, interrupts and daisy chains
    logic irq_oe_q, dma_busy;
    assign dma_busy = st_q inside {TCB_DREQ, TCB_DGNT, TCB_DADR,
                                   TCB_DSTB, TCB_DDAT, TCB_DEND};
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            bus_parity_error_bit_out <= 1'b0;
            irq_oe_q    <= 1'b0;
            biako_n_out <= 1'b1;
            bdmgo_n_out <= 1'b1;
        end
        else
        begin
            if (perr_set)
                bus_parity_error_bit_out <= 1'b1;    // R10
            else if (parity_clr_in || clr)
                bus_parity_error_bit_out <= 1'b0;
            irq_oe_q    <= irq_req_in && !clr;       // R5
            // Own acknowledge and grant never passed on
            biako_n_out <= (irq_req_in || st_q == TCB_VEC)
                           ? 1'b1 : f_q[`TCB_I_IAKI];           // R13
            bdmgo_n_out <= (dma_busy || dma_valid_in)
                           ? 1'b1 : f_q[`TCB_I_DMGI];           // R13
        end
    end

    // Control line drivers pull low when enabled; address/data line drivers drive the inverse of drv_q when enabled
    assign bdal_n_out = ~drv_q;
    assign bdal_n_oe_out = drv_oe_q;
    assign {bsync_n_out, bdin_n_out, bdout_n_out, brply_n_out} = 4'h0;
    assign {bwtbt_n_out, birq4_n_out, birq5_n_out} = 3'h0;
    assign {bdmr_n_out, bsack_n_out} = 2'h0;
    assign bsync_n_oe_out = sync_oe_q;
    assign bdin_n_oe_out = din_oe_q;
    assign bdout_n_oe_out = dout_oe_q;
    assign brply_n_oe_out = rply_oe_q;
    assign bwtbt_n_oe_out = wtbt_oe_q;
    assign birq4_n_oe_out = irq_oe_q;
    assign birq5_n_oe_out = irq_oe_q;
    assign bdmr_n_oe_out = dmr_oe_q;
    assign bsack_n_oe_out = sack_oe_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    chk_irq_both: assert property (irq_req_in && !clr |=> // R5
        birq4_n_oe_out && birq5_n_oe_out) else $error("irq levels split");
    chk_msb_nodata: assert property (st_q inside {TCB_RPLY, TCB_VEC, // R2
        TCB_DDAT} |-> drv_oe_q[21:18] == 4'h0) else $error("msb in data");
    chk_init_clear: assert property (init_a |=> controller_clear_out) // R7
        else $error("init gave no clear");
    chk_init_notest: assert property (init_a && dcok && dcok_prev_q // R8
        |=> !self_test_start_out) else $error("self-test on init");
    chk_perr_set: assert property (perr_set |=> // R10
        bus_parity_error_bit_out) else $error("parity error lost");
    chk_pio_reply: assert property (st_q == TCB_PIO && pio_ack_in && !clr // R12
        |=> brply_n_oe_out ##1 brply_n_oe_out || !(din_a || dout_a))
        else $error("no reply to access");
    chk_dma_req: assert property (st_q == TCB_IDLE && dma_valid_in && // R9
        dma_ready_out && !clr |=> bdmr_n_oe_out && !bsync_n_oe_out)
        else $error("dma request not raised");
    chk_grant_pass: assert property (!dma_valid_in && st_q == TCB_IDLE // R13
        |=> bdmgo_n_out == $past(f_q[`TCB_I_DMGI])) else $error("grant held");
    chk_sync_addr: assert property (st_q == TCB_DADR |-> // R1
        drv_oe_q == 22'h3fffff) else $error("sync without address");

    cov_pio: cover property (st_q == TCB_PIO ##1 st_q == TCB_RPLY);
    cov_dma_rd: cover property (st_q == TCB_DDAT && rply_a && !dma_q.write);
    cov_iak: cover property (irq_taken_out);
    cov_perr: cover property (perr_set);
endmodule

/* tcb_cfg.svh */
// Constants of the tape coupler host bus port
`ifndef TCB_CFG_SVH
`define TCB_CFG_SVH

// Synchronised pin vector layout
`define TCB_NIN      33
`define TCB_I_SYNC   22
`define TCB_I_DIN    23
`define TCB_I_DOUT   24
`define TCB_I_RPLY   25
`define TCB_I_WTBT   26
`define TCB_I_BS7    27
`define TCB_I_IAKI   28
`define TCB_I_DMGI   29
`define TCB_I_INIT   30
`define TCB_I_POK    31
`define TCB_I_DCOK   32
`define TCB_IN_RST   33'h07fffffff

// Address and data line fields
`define TCB_SW_W     9
`define TCB_SEL_HI   12
`define TCB_SEL_LO   4
`define TCB_IDX_HI   3
`define TCB_IDX_LO   1
`define TCB_PAR_ERR  16
`define TCB_PAR_EN   17
`define TCB_AONLY_LO 18
`define TCB_BDAL_W   22
`define TCB_DATA_W   16

`endif

/* tcb_host_model.sv */
// Host memory and grant arbiter seen from the bus port
`timescale 1ns/10ps
module tcb_host_model (
    input  wire logic        clk_in,
    input  wire logic [21:0] bdal_n_in,
    input  wire logic        bsync_n_in,
    input  wire logic        bdin_n_in,
    input  wire logic        bdout_n_in,
    input  wire logic        bsack_n_in,
    input  wire logic        bdmr_n_in,
    input  wire logic        perr_in,
    input  wire logic [3:0]  delay_in,
    output logic      [21:0] bdal_out,
    output logic             rply_out,
    output logic             bdmgi_n_out,
    output logic      [21:0] addr_out,
    output logic      [15:0] wdata_out
);
    logic       cyc_q;
    logic [3:0] wait_q;
    initial
    begin
        bdal_out = '0;
        rply_out = 1'b0;
        bdmgi_n_out = 1'b1;
        cyc_q = 1'b0;
        wait_q = 4'h0;
    end
    // ==========================================
    // Grant and memory slave, driven off the falling edge
    always @(negedge clk_in)
    begin
        bdmgi_n_out <= !(!bdmr_n_in && bsack_n_in);
        if (!bsack_n_in && !bsync_n_in && !cyc_q)
        begin
            cyc_q    <= 1'b1;
            addr_out <= ~bdal_n_in;
        end
        if (cyc_q && (!bdin_n_in || !bdout_n_in))
        begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == delay_in)
            begin
                rply_out <= 1'b1;
                if (!bdin_n_in)
                    bdal_out <= {5'h0, perr_in, addr_out[15:0] ^ 16'h5555};
                else
                    wdata_out <= ~bdal_n_in[15:0];
            end
        end
        else if (bdin_n_in && bdout_n_in)
        begin
            rply_out <= 1'b0;
            bdal_out <= '0;
            wait_q   <= 4'h0;
        end
        if (bsync_n_in)
            cyc_q <= 1'b0;
    end
endmodule

/* tcb_pkg.sv */
// Types of the tape coupler host bus port
package tcb_pkg;
    typedef enum logic [3:0] {
        TCB_IDLE = 4'h0, TCB_ADDR = 4'h1, TCB_PIO  = 4'h3, TCB_RPLY = 4'h2,
        TCB_WAIT = 4'h6, TCB_VEC  = 4'h7, TCB_DREQ = 4'h5, TCB_DGNT = 4'h4,
        TCB_DADR = 4'hc, TCB_DSTB = 4'hd, TCB_DDAT = 4'hf, TCB_DEND = 4'he
    } tcb_state_t;

    typedef struct packed {
        logic [2:0] idx;
        logic       write;
        logic       byte_op;
        logic       addr0;
    } tcb_pio_t;

    typedef struct packed {
        logic [21:0] addr;
        logic        write;
        logic [15:0] wdata;
    } tcb_dma_t;
endpackage

/* testbench.sv */
// Self-checking bench for the host bus port
`timescale 1ns/10ps
module testbench;
    import tcb_pkg::*;
    logic clk = 0, rstn = 0, dcok = 0, init = 0, iak = 0, irq = 0;
    logic h_sync = 0, h_din = 0, h_dout = 0, h_wtbt = 0, h_bs7 = 0;
    logic ack = 0, acked = 0, perr = 0, pclr = 0, dv = 0, ok, h_dmg = 0;
    logic d_sync, d_din, d_dout, d_rply, d_wtbt, i4, i5, dmr, sack, m_rply;
    logic dmgi_n, iako_n, dmgo_n, pv, tk, drdy, dn, pe, clr, st;
    logic [3:0]  dly = 4'h0;
    logic [15:0] wd, drd, m_wd, cap_wd;
    logic [21:0] h_bdal = '0, m_bdal, d_bdal, d_bdal_oe, bus, rd_bus, m_addr;
    tcb_pio_t preq, cap;
    tcb_dma_t dreq = '0;
    int n_errors = 0, check_count = 0, st_n = 0, tk_n = 0, dn_n = 0;
    int wt_n = 0;
    // Asserted lines: any party pulling low
    assign bus = (d_bdal_oe & ~d_bdal) | h_bdal | m_bdal;
    always #25 clk = ~clk;
    tcb_bus_port i_tcb_bus_port (
        .clk_in(clk), .resetn_in(rstn), .bdal_n_in(~bus),
        .bdal_n_out(d_bdal), .bdal_n_oe_out(d_bdal_oe),
        .bsync_n_in(~(d_sync | h_sync)), .bsync_n_out(),
        .bsync_n_oe_out(d_sync), .bdin_n_in(~(d_din | h_din)),
        .bdin_n_out(), .bdin_n_oe_out(d_din), .bdout_n_in(~(d_dout | h_dout)),
        .bdout_n_out(), .bdout_n_oe_out(d_dout),
        .brply_n_in(~(d_rply | m_rply)), .brply_n_out(),
        .brply_n_oe_out(d_rply), .bwtbt_n_in(~(d_wtbt | h_wtbt)),
        .bwtbt_n_out(), .bwtbt_n_oe_out(d_wtbt), .bbs7_n_in(~h_bs7),
        .birq4_n_out(), .birq4_n_oe_out(i4), .birq5_n_out(),
        .birq5_n_oe_out(i5), .biaki_n_in(~iak), .biako_n_out(iako_n),
        .bdmr_n_out(), .bdmr_n_oe_out(dmr),
        .bdmgi_n_in(dmgi_n & ~h_dmg),
        .bdmgo_n_out(dmgo_n), .bsack_n_out(), .bsack_n_oe_out(sack),
        .binit_n_in(~init), .bdcok_in(dcok), .bpok_in(dcok),
        .address_select_switches_in(9'h0a5), .pio_req_out(preq),
        .pio_valid_out(pv), .pio_wdata_out(wd), .pio_ack_in(ack),
        .pio_rdata_in(16'h5a50 | 16'(preq.idx)), .irq_req_in(irq),
        .irq_vector_in(16'h00b4), .irq_taken_out(tk), .dma_req_in(dreq),
        .dma_valid_in(dv), .dma_ready_out(drdy), .dma_done_out(dn),
        .dma_rdata_out(drd), .bus_parity_error_bit_out(pe),
        .parity_clr_in(pclr), .controller_clear_out(clr),
        .self_test_start_out(st));
    tcb_host_model i_tcb_host_model (
        .clk_in(clk), .bdal_n_in(~bus), .bsync_n_in(~(d_sync | h_sync)),
        .bdin_n_in(~(d_din | h_din)), .bdout_n_in(~(d_dout | h_dout)),
        .bsack_n_in(~sack), .bdmr_n_in(~dmr), .perr_in(perr),
        .delay_in(dly), .bdal_out(m_bdal), .rply_out(m_rply),
        .bdmgi_n_out(dmgi_n), .addr_out(m_addr), .wdata_out(m_wd));
    // ==========================================
    // Microprocessor stand-in and pulse counters
    always @(negedge clk)
    begin
        ack <= pv && !ack && !acked;
        acked <= pv && (acked || ack);
        if (ack)
        begin
            cap <= preq;
            cap_wd <= wd;
        end
    end
    always @(posedge clk)
    begin
        st_n += (st === 1'b1);
        tk_n += (tk === 1'b1);
        dn_n += (dn === 1'b1);
        wt_n += (d_wtbt === 1'b1);
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [21:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            n_errors++;
        end
    endtask
    task automatic pio(input logic [21:0] a, input logic bs7, wr, bw,
                       input logic [15:0] d);
        @(negedge clk);
        h_bdal = a;
        h_bs7 = bs7;
        h_wtbt = wr;
        @(negedge clk) h_sync = 1;
        @(negedge clk) h_bdal = wr ? {6'h0, d} : '0;
        h_wtbt = bw;
        h_dout = wr;
        h_din = !wr;
        repeat (30) if (!d_rply) @(negedge clk);
        ok = d_rply;
        rd_bus = bus;
        h_din = 0;
        h_dout = 0;
        repeat (30) if (d_rply) @(negedge clk);
        chk("rply_release", 0, d_rply);
        h_sync = 0;
        h_bs7 = 0;
        h_wtbt = 0;
        h_bdal = '0;
        repeat (6) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_power;
        @(negedge clk) dcok = 1;
        repeat (12) @(negedge clk);
        chk("selftest_pwrup", 1, st_n);
        chk("clear_off", 0, clr);
        init = 1;
        repeat (8) @(negedge clk);
        chk("clear_init", 1, clr);
        init = 0;
        repeat (10) @(negedge clk);
        chk("selftest_init", 1, st_n);
        chk("clear_init_off", 0, clr);
    endtask
    task automatic t_read;
        for (int i = 0; i < 8; i++)
        begin
            pio(22'h3fea50 | 22'(i << 1), 1, 0, 0, 16'h0);
            chk("read_reply", 1, ok);
            chk("read_word", 22'h005a50 | 22'(i), rd_bus);
            chk("read_idx", 22'(i), cap.idx);
            chk("read_dir", 0, cap.write);
        end
    endtask
    task automatic t_write;
        for (int b = 0; b < 2; b++)
        begin
            pio(22'h3fea50 | 22'((5 + 2 * b) << 1) | 22'(b == 0), 1, 1, !b,
                16'hc3a7);
            chk("write_addr0", 22'(b == 0), cap.addr0);
            chk("write_reply", 1, ok);
            chk("write_idx", 22'(5 + 2 * b), cap.idx);
            chk("write_dir", 1, cap.write);
            chk("write_byte", 22'(b == 0), cap.byte_op);
            chk("write_data", 16'hc3a7, cap_wd);
        end
    endtask
    task automatic t_refuse;
        pio(22'h3feb50, 1, 0, 0, 16'h0);
        chk("other_window", 0, ok);
        pio(22'h3fea54, 0, 0, 0, 16'h0);
        chk("no_page_sel", 0, ok);
    endtask
    task automatic t_irq;
        iak = 1;
        repeat (6) @(negedge clk);
        chk("iack_pass", 0, iako_n);
        iak = 0;
        irq = 1;
        repeat (6) @(negedge clk);
        chk("irq_lvl4", 1, i4);
        chk("irq_lvl5", 1, i5);
        iak = 1;
        h_din = 1;
        repeat (30) if (!d_rply) @(negedge clk);
        chk("vector", 22'h0000b4, bus);
        chk("iack_held", 1, iako_n);
        h_din = 0;
        iak = 0;
        irq = 0;
        repeat (30) if (d_rply) @(negedge clk);
        repeat (6) @(negedge clk);
        chk("irq_taken", 1, tk_n);
        chk("irq_drop", 0, i4 | i5);
    endtask
    task automatic dma(input logic wr, pe_in, input logic [3:0] dl,
                       input logic exp_pe);
        int n, w;
        n = dn_n;
        w = wt_n;
        perr = pe_in;
        dly = dl;
        dreq = '{addr: 22'h12a46c, write: wr, wdata: 16'h9e31};
        dv = 1;
        repeat (20) if (!drdy) @(negedge clk);
        @(negedge clk) dv = 0;
        repeat (2) @(negedge clk);
        chk("grant_held", 1, dmgo_n);
        repeat (100) if (dn_n == n) @(negedge clk);
        chk("dma_done", 22'(n + 1), 22'(dn_n));
        chk("dma_addr", 22'h12a46c, m_addr);
        chk("dma_wtbt", 22'(wr), 22'(wt_n != w));
        if (wr)
            chk("dma_wdata", 16'h9e31, m_wd);
        else
            chk("dma_rdata", 16'ha46c ^ 16'h5555, drd);
        chk("parity_bit", exp_pe, pe);
        chk("sack_free", 0, sack);
        repeat (4) @(negedge clk);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (4) @(negedge clk);
        chk("clear_in_reset", 1, clr);
        rstn = 1;
        t_power;
        t_read;
        t_write;
        t_refuse;
        t_irq;
        iak = 0;
        @(negedge clk);
        chk("grant_idle", 1, dmgo_n);
        h_dmg = 1;
        repeat (6) @(negedge clk);
        chk("grant_pass", 0, dmgo_n);
        h_dmg = 0;
        repeat (6) @(negedge clk);
        dma(0, 0, 4'h0, 0);
        dma(1, 1, 4'h3, 0);
        dma(0, 1, 4'h3, 1);
        pclr = 1;
        repeat (2) @(negedge clk);
        pclr = 0;
        @(negedge clk);
        chk("parity_clear", 0, pe);
        tally_and_finish;
    end
    initial
    begin
        #2000000;
        n_errors++;
        tally_and_finish;
    end
endmodule
